// ---- core/ocp_oled_cmd_and_pixel_ram_map.sv ----
// Command decoder, gray table, clock divider and remappable pixel memory
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Clock divide opcode: next byte low nibble sets divide ratio 1..16, reset 2.
// - Same byte high nibble sets oscillator frequency, higher value faster, reset 0.
// - Gray table opcode takes eight argument bytes for levels one to fifteen, reset one.
// - Byte one bits 2..0 is level 1; later bytes hold even then odd level.
// - Pixel memory holds 128 by 80 pixels of 4 bits and feeds the display.
// - Column and row driver output order are remappable by software.
// - Horizontal mode fills a row through column 3F then wraps to next row.
// - Vertical mode runs down 80 rows then moves to the next column.
// - Byte low nibble feeds even segment, high nibble the following odd segment.
// - A full screen is 5120 bytes; the last lands at column 3F row 4F.
// - Column remap, nibble remap and row remap are independent options.
module ocp_oled_cmd_and_pixel_ram_map #(
  parameter int DATA_W = 32
) (
  input wire logic i_clk, // 250 MHz clock
  input wire logic i_reset, // Synchronous reset, active high
  input wire logic i_host_valid, // Host byte present this cycle
  input wire logic i_host_is_data, // 1 display data, 0 command or argument
  input wire logic [7:0] i_host_byte, // Host byte
  input wire logic [7:0] i_addr, // Register byte address
  input wire logic [DATA_W-1:0] i_wdata, // Register write data
  input wire logic i_wr, // Register write strobe
  input wire logic i_rd, // Register read strobe
  output logic [DATA_W-1:0] o_rdata, // Read data, cycle after strobe
  input wire logic [6:0] i_scan_seg, // Column driver output index 0..127
  input wire logic [6:0] i_scan_row, // Row driver output index 0..79
  output logic [3:0] o_pixel, // Pixel value for scan position
  output logic o_display_clock, // One-cycle display clock tick, held high every cycle when the stored ratio is 0
  output logic [3:0] o_osc_freq // Oscillator frequency setting
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (DATA_W != 32)
  begin : g_bad_width
    $error("DATA_W must be 32");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  ocp_pkg::ocp_state_e state;
  logic [3:0] gray_cnt;
  logic [3:0] div_ratio;
  logic [3:0] div_cnt;
  logic [2:0] gray_steps [1:15];
  logic [4:0] config_bits;
  logic [ocp_pkg::COL_BITS-1:0] col;
  logic [ocp_pkg::ROW_BITS-1:0] row;
  logic [7:0] pixel_memory [0:ocp_pkg::MEM_DEPTH-1];
  logic cmd_byte;
  logic data_byte;
  logic col_remap;
  logic nib_remap;
  logic vert_inc;
  logic row_remap;

  // Byte classification and option bits
  assign cmd_byte = i_host_valid && !i_host_is_data;
  assign data_byte = i_host_valid && i_host_is_data;
  assign col_remap = config_bits[ocp_pkg::CFG_COL_REMAP];
  assign nib_remap = config_bits[ocp_pkg::CFG_NIB_REMAP];
  assign vert_inc = config_bits[ocp_pkg::CFG_VERT_INC];
  assign row_remap = config_bits[ocp_pkg::CFG_ROW_REMAP];

  // Linear memory index from row and column address
  function automatic logic [12:0] mem_index(input logic [6:0] r, input logic [5:0] c);
    mem_index = {r, c};
  endfunction

  // Packs up to eight gray levels, none above 15, into 4-bit fields from a first level
  function automatic logic [31:0] pack_gray(input logic [2:0] g [1:15], input int first);
    logic [31:0] v;
    v = 32'h0000_0000;
    for (int i = 0; i < 8; i++)
    begin
      if (first + i <= 15)
        v[4*i +: 3] = g[first + i];
    end
    pack_gray = v;
  endfunction

  // ----------------------------------------
  // Command decoder
  // ----------------------------------------
  // Opcode and argument sequencing; other opcodes are ignored here
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state <= ocp_pkg::OCP_IDLE;
      gray_cnt <= 4'h0;
    end
    else if (cmd_byte)
    begin
      case (state)
        ocp_pkg::OCP_IDLE:
        begin
          if (i_host_byte == ocp_pkg::OP_CLOCK_DIV)
            state <= ocp_pkg::OCP_CLK_ARG;
          else if (i_host_byte == ocp_pkg::OP_GRAY_TABLE)
          begin
            state <= ocp_pkg::OCP_GRAY_ARG;
            gray_cnt <= 4'h0;
          end
        end
        ocp_pkg::OCP_CLK_ARG:
          state <= ocp_pkg::OCP_IDLE;
        ocp_pkg::OCP_GRAY_ARG:
        begin
          gray_cnt <= gray_cnt + 4'h1;
          if (gray_cnt == ocp_pkg::GRAY_ARG_LAST)
            state <= ocp_pkg::OCP_IDLE;
        end
        default:
          state <= ocp_pkg::OCP_IDLE;
      endcase
    end
  end

  // Clock divide and oscillator settings from the argument byte
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      div_ratio <= ocp_pkg::DIV_RESET;
      o_osc_freq <= ocp_pkg::OSC_RESET;
    end
    else if (cmd_byte && state == ocp_pkg::OCP_CLK_ARG)
    begin
      div_ratio <= i_host_byte[3:0];
      o_osc_freq <= i_host_byte[7:4];
    end
  end

  // Gray table capture, first byte one level, later bytes two
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      for (int i = 1; i <= 15; i++)
        gray_steps[i] <= ocp_pkg::GRAY_RESET;
    end
    else if (cmd_byte && state == ocp_pkg::OCP_GRAY_ARG)
    begin
      if (gray_cnt == 4'h0)
        gray_steps[1] <= i_host_byte[2:0];
      else
      begin
        gray_steps[2 * gray_cnt] <= i_host_byte[2:0];
        gray_steps[2 * gray_cnt + 1] <= i_host_byte[6:4];
      end
    end
  end

  // ----------------------------------------
  // Display clock divider
  // ----------------------------------------
  // Ticks once every divide-ratio cycles, ratio is stored value plus one
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      div_cnt <= 4'h0;
      o_display_clock <= 1'b0;
    end
    else if (div_cnt >= div_ratio)
    begin
      div_cnt <= 4'h0;
      o_display_clock <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 4'h1;
      o_display_clock <= 1'b0;
    end
  end

  // ----------------------------------------
  // Write address pointer
  // ----------------------------------------
  // Advances per data byte in horizontal or vertical order
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      col <= '0;
      row <= '0;
    end
    else if (i_wr && i_addr == ocp_pkg::REG_POINTER)
    begin
      col <= i_wdata[ocp_pkg::COL_BITS-1:0];
      row <= (i_wdata[ocp_pkg::PTR_ROW_LSB +: ocp_pkg::ROW_BITS] > ocp_pkg::ROW_LAST) ?
             ocp_pkg::ROW_LAST : i_wdata[ocp_pkg::PTR_ROW_LSB +: ocp_pkg::ROW_BITS];
    end
    else if (data_byte)
    begin
      if (!vert_inc)
      begin
        col <= col + 6'h01;
        if (col == ocp_pkg::COL_LAST)
          row <= (row == ocp_pkg::ROW_LAST) ? 7'h00 : row + 7'h01;
      end
      else
      begin
        row <= (row == ocp_pkg::ROW_LAST) ? 7'h00 : row + 7'h01;
        if (row == ocp_pkg::ROW_LAST)
          col <= col + 6'h01;
      end
    end
  end

  // ----------------------------------------
  // Pixel memory
  // ----------------------------------------
  // Column remap mirrors the address, nibble remap swaps halves
  always_ff @(posedge i_clk)
  begin
    if (data_byte)
      pixel_memory[mem_index(row, col_remap ? ocp_pkg::COL_LAST - col : col)] <=
        nib_remap ? {i_host_byte[3:0], i_host_byte[7:4]} : i_host_byte;
  end

  // Scan read: even segment takes low nibble, row order optionally mirrored
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_pixel <= 4'h0;
    else if (i_scan_seg[0])
      o_pixel <= pixel_memory[mem_index(row_remap ? ocp_pkg::ROW_LAST - i_scan_row : i_scan_row,
                                        i_scan_seg[6:1])][7:4];
    else
      o_pixel <= pixel_memory[mem_index(row_remap ? ocp_pkg::ROW_LAST - i_scan_row : i_scan_row,
                                        i_scan_seg[6:1])][3:0];
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  // Option bits written by software
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      config_bits <= ocp_pkg::CFG_RESET;
    else if (i_wr && i_addr == ocp_pkg::REG_CONFIG)
      config_bits <= {i_wdata[ocp_pkg::CFG_ROW_REMAP], 1'b0, i_wdata[2:0]};
  end

  // Read data, zero for unmapped addresses
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_rdata <= '0;
    else if (i_rd)
    begin
      if (i_addr == ocp_pkg::REG_CONFIG)
        o_rdata <= {27'h0000000, config_bits};
      else if (i_addr == ocp_pkg::REG_CLOCK)
        o_rdata <= {24'h000000, o_osc_freq, div_ratio};
      else if (i_addr == ocp_pkg::REG_POINTER)
        o_rdata <= {17'h00000, row, 2'h0, col};
      else if (i_addr == ocp_pkg::REG_GRAY_LO)
        o_rdata <= pack_gray(gray_steps, 1);
      else if (i_addr == ocp_pkg::REG_GRAY_HI)
        o_rdata <= pack_gray(gray_steps, 9);
      else
        o_rdata <= '0;
    end
    else
      o_rdata <= '0;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_div_arg;
    @(posedge i_clk) disable iff (i_reset)
    (cmd_byte && state == ocp_pkg::OCP_CLK_ARG) |=> (div_ratio == $past(i_host_byte[3:0]));
  endproperty
  a_div_arg: assert property (p_div_arg) else $error("divide ratio not taken");

  property p_osc_arg;
    @(posedge i_clk) disable iff (i_reset)
    (cmd_byte && state == ocp_pkg::OCP_CLK_ARG) |=> (o_osc_freq == $past(i_host_byte[7:4]));
  endproperty
  a_osc_arg: assert property (p_osc_arg) else $error("oscillator setting not taken");

  property p_gray_start;
    @(posedge i_clk) disable iff (i_reset)
    (cmd_byte && state == ocp_pkg::OCP_IDLE && i_host_byte == ocp_pkg::OP_GRAY_TABLE)
      |=> (state == ocp_pkg::OCP_GRAY_ARG && gray_cnt == 4'h0);
  endproperty
  a_gray_start: assert property (p_gray_start) else $error("gray table not started");

  property p_gray_end;
    @(posedge i_clk) disable iff (i_reset)
    (cmd_byte && state == ocp_pkg::OCP_GRAY_ARG && gray_cnt == 4'h7) |=> (state == ocp_pkg::OCP_IDLE);
  endproperty
  a_gray_end: assert property (p_gray_end) else $error("gray table not closed after eight bytes");

  property p_gray_pair;
    @(posedge i_clk) disable iff (i_reset)
    (cmd_byte && state == ocp_pkg::OCP_GRAY_ARG && gray_cnt == 4'h3)
      |=> (gray_steps[6] == $past(i_host_byte[2:0]) && gray_steps[7] == $past(i_host_byte[6:4]));
  endproperty
  a_gray_pair: assert property (p_gray_pair) else $error("gray pair misplaced");

  property p_horiz_wrap;
    @(posedge i_clk) disable iff (i_reset)
    (data_byte && !vert_inc && col == 6'h3f && row == 7'h4f && !i_wr) |=> (col == 6'h00 && row == 7'h00);
  endproperty
  a_horiz_wrap: assert property (p_horiz_wrap) else $error("last byte did not wrap");

  property p_vert_step;
    @(posedge i_clk) disable iff (i_reset)
    (data_byte && vert_inc && row == 7'h4f && !i_wr) |=> (row == 7'h00 && col == $past(col) + 6'h01);
  endproperty
  a_vert_step: assert property (p_vert_step) else $error("vertical advance wrong");

  property p_arg_not_opcode;
    @(posedge i_clk) disable iff (i_reset)
    (cmd_byte && state == ocp_pkg::OCP_CLK_ARG) |=> (state == ocp_pkg::OCP_IDLE);
  endproperty
  a_arg_not_opcode: assert property (p_arg_not_opcode) else $error("argument decoded as opcode");

  property p_tick_one_cycle;
    @(posedge i_clk) disable iff (i_reset)
    (o_display_clock && div_ratio != 4'h0) |=> !o_display_clock;
  endproperty
  a_tick_one_cycle: assert property (p_tick_one_cycle) else $error("display clock tick held too long");

  property p_cfg_options;
    @(posedge i_clk) disable iff (i_reset)
    (i_wr && i_addr == ocp_pkg::REG_CONFIG)
      |=> (vert_inc == $past(i_wdata[2]) && row_remap == $past(i_wdata[4]) && col_remap == $past(i_wdata[0]));
  endproperty
  a_cfg_options: assert property (p_cfg_options) else $error("option bits not taken");

endmodule

`default_nettype wire

// ---- core/ocp_pkg.sv ----
// Shared constants for the OLED command decoder and pixel memory block
package ocp_pkg;
  // ----------------------------------------
  // Command opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_CLOCK_DIV = 8'hb3;
  localparam logic [7:0] OP_GRAY_TABLE = 8'hb8;
  localparam logic [3:0] GRAY_ARG_LAST = 4'h7;

  // ----------------------------------------
  // Pixel memory geometry
  // ----------------------------------------
  localparam int COL_BITS = 6;
  localparam int ROW_BITS = 7;
  localparam int SEG_BITS = 7;
  localparam int MEM_DEPTH = 5120;
  localparam logic [5:0] COL_LAST = 6'h3f;
  localparam logic [6:0] ROW_LAST = 7'h4f;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_CLOCK = 8'h04;
  localparam logic [7:0] REG_POINTER = 8'h08;
  localparam logic [7:0] REG_GRAY_LO = 8'h0c;
  localparam logic [7:0] REG_GRAY_HI = 8'h10;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CFG_COL_REMAP = 0;
  localparam int CFG_NIB_REMAP = 1;
  localparam int CFG_VERT_INC = 2;
  localparam int CFG_ROW_REMAP = 4;
  localparam int PTR_ROW_LSB = 8;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [3:0] DIV_RESET = 4'h1;
  localparam logic [3:0] OSC_RESET = 4'h0;
  localparam logic [2:0] GRAY_RESET = 3'h1;
  localparam logic [4:0] CFG_RESET = 5'h00;

  // Decoder states
  typedef enum logic [1:0] {OCP_IDLE, OCP_CLK_ARG, OCP_GRAY_ARG} ocp_state_e;
endpackage

// ---- testbench/ocp_host_model.sv ----
// Host model that sends command, argument and display data bytes
`timescale 1ns/1ps
`default_nettype none
module ocp_host_model (
  input wire logic i_clk, // Clock
  output logic o_valid, // Byte present
  output logic o_is_data, // 1 data, 0 command or argument
  output logic [7:0] o_byte // Byte value
);
  // Row period the host would program: phase one plus phase two plus top gray width
  localparam int ROW_PERIOD = 3 + 5 + 29;
  // The recommended sum must match the row period default of 37 clocks
  if (ROW_PERIOD != 37)
  begin : g_row_period
    $error("row period sum differs from its default");
  end
  // Idle lines at time zero
  initial
  begin
    o_valid = 1'b0;
    o_is_data = 1'b0;
    o_byte = 8'h00;
  end
  // One byte per call, each marked as command or data; released line shows the inverse
  task automatic send(input logic is_data, input logic [7:0] b);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_is_data <= is_data;
    o_byte <= b;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_byte <= ~b;
  endtask
  // Gray table opcode followed by exactly eight argument bytes
  task automatic gray_table(input logic [7:0] args [0:7]);
    send(1'b0, ocp_pkg::OP_GRAY_TABLE);
    foreach (args[i]) send(1'b0, args[i]);
  endtask
endmodule
`default_nettype wire

// ---- testbench/ocp_oled_cmd_and_pixel_ram_map_test.sv ----
// Self-checking testbench for the command decoder and pixel memory
`timescale 1ns/1ps
`default_nettype none
module ocp_oled_cmd_and_pixel_ram_map_test;
  logic i_clk, i_reset, i_wr, i_rd, hv, hd, o_display_clock;
  logic [7:0] hb, i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [6:0] i_scan_seg, i_scan_row;
  logic [3:0] o_pixel, o_osc_freq;
  int num_errors = 0;
  int tests_run = 0;
  logic [7:0] ga [0:7] = '{8'h07, 8'hb3, 8'h12, 8'h45, 8'h56, 8'h67, 8'h70, 8'h21};
  logic [2:0] lv [1:15];
  logic [31:0] glo, ghi;

  ocp_host_model i_host (.i_clk(i_clk), .o_valid(hv), .o_is_data(hd), .o_byte(hb));
  ocp_oled_cmd_and_pixel_ram_map i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_host_valid(hv),
    .i_host_is_data(hd), .i_host_byte(hb), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_scan_seg(i_scan_seg), .i_scan_row(i_scan_row),
    .o_pixel(o_pixel), .o_display_clock(o_display_clock), .o_osc_freq(o_osc_freq));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 check($sformatf("reg %h", a), o_rdata, exp);
  endtask
  // Pixel expected from the byte pattern of stream index n
  function automatic logic [7:0] pat(input int n);
    return 8'(n * 37 + n / 64);
  endfunction
  task automatic scan(input int column_driver_output, input int row, input logic [3:0] exp);
    @(posedge i_clk);
    i_scan_seg <= 7'(column_driver_output);
    i_scan_row <= 7'(row);
    @(posedge i_clk);
    #1 check($sformatf("pixel %0d %0d", column_driver_output, row), {28'h0, o_pixel}, {28'h0, exp});
  endtask
  task automatic scan_n(input int column_driver_output, input int row, input int n);
    logic [7:0] b;
    b = pat(n);
    scan(column_driver_output, row, column_driver_output[0] ? b[7:4] : b[3:0]);
  endtask
  // Gap in clocks between two display clock ticks
  task automatic tick_gap(input int exp);
    int t;
    int n;
    t = 0;
    n = 1;
    while (o_display_clock !== 1'b1 && t < 40)
    begin
      @(posedge i_clk);
      #1 t++;
    end
    @(posedge i_clk);
    #1;
    while (o_display_clock !== 1'b1 && n < 40)
    begin
      @(posedge i_clk);
      #1 n++;
    end
    if (t >= 40 || n >= 40)
    begin
      num_errors++;
      close_out();
    end
    else
      check("tick gap", n, exp);
  endtask

  // ----------------------------------------
  // Clock and sequence
  // ----------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial
  begin
    {i_reset, i_wr, i_rd, i_addr, i_wdata, i_scan_seg, i_scan_row} = '0;
    i_reset = 1'b1;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(8'h04, 32'h01);
    rd(8'h0c, 32'h11111111);
    rd(8'h10, 32'h01111111);
    rd(8'h20, 32'h0);
    tick_gap(2);
    $display("test reset done");
    i_host.send(1'b0, ocp_pkg::OP_CLOCK_DIV);
    i_host.send(1'b0, 8'h5a);
    wr(8'h04, 32'hffff);
    rd(8'h04, 32'h5a);
    check("osc", {28'h0, o_osc_freq}, 32'h5);
    tick_gap(11);
    $display("test clock done");
    i_host.gray_table(ga);
    lv[1] = ga[0][2:0];
    for (int k = 1; k < 8; k++)
    begin
      lv[2 * k] = ga[k][2:0];
      lv[2 * k + 1] = ga[k][6:4];
    end
    glo = '0;
    ghi = '0;
    for (int i = 0; i < 8; i++) glo[4 * i +: 4] = {1'b0, lv[i + 1]};
    for (int i = 0; i < 7; i++) ghi[4 * i +: 4] = {1'b0, lv[i + 9]};
    rd(8'h0c, glo);
    rd(8'h10, ghi);
    rd(8'h04, 32'h5a);
    $display("test gray done");
    for (int n = 0; n < 5120; n++) i_host.send(1'b1, pat(n));
    rd(8'h08, 32'h0);
    scan_n(2, 0, 1);
    scan_n(3, 0, 1);
    scan_n(127, 0, 63);
    scan_n(0, 1, 64);
    scan_n(126, 79, 5119);
    scan_n(127, 79, 5119);
    $display("test horizontal done");
    wr(8'h00, 32'h4);
    wr(8'h08, 32'h0);
    for (int n = 0; n < 81; n++) i_host.send(1'b1, pat(n + 7));
    scan_n(1, 79, 86);
    scan_n(2, 0, 87);
    $display("test vertical done");
    wr(8'h00, 32'h1);
    wr(8'h08, 32'h0);
    i_host.send(1'b1, 8'h5c);
    scan(126, 0, 4'hc);
    scan(127, 0, 4'h5);
    wr(8'h00, 32'h2);
    wr(8'h08, 32'h0);
    i_host.send(1'b1, 8'h5c);
    scan(0, 0, 4'h5);
    scan(1, 0, 4'hc);
    $display("test single remap done");
    wr(8'h00, 32'h3);
    wr(8'h08, 32'h0);
    i_host.send(1'b1, 8'h5c);
    scan(126, 0, 4'h5);
    scan(127, 0, 4'hc);
    wr(8'h00, 32'h13);
    rd(8'h00, 32'h13);
    scan(126, 79, 4'h5);
    $display("test remap done");
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h01);
    rd(8'h0c, 32'h11111111);
    rd(8'h08, 32'h0);
    tick_gap(2);
    $display("test second reset done");
    close_out();
  end
endmodule
`default_nettype wire
